// *** shared/acc_pkg.sv ***
// Package of constants, register map and types for the comparator control block.
package acc_pkg;
    localparam int ACC_NUM = 3;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] ACC_CTRL0_OFS = 8'h00;
    localparam logic [7:0] ACC_CTRL1_OFS = 8'h04;
    localparam logic [7:0] ACC_CTRL2_OFS = 8'h08;
    localparam logic [7:0] ACC_RESULT_OFS = 8'h0c;
    localparam logic [7:0] ACC_FLAG_OFS = 8'h10;
    localparam logic [7:0] ACC_ENABLE_OFS = 8'h14;
    localparam logic [7:0] ACC_IRQCTL_OFS = 8'h18;
    // Control field positions.
    localparam int ACC_ON_BIT = 7;
    localparam int ACC_PINEN_BIT = 6;
    localparam int ACC_INV_BIT = 5;
    localparam int ACC_EDGE_LSB = 3;
    localparam int ACC_PLUS_BIT = 2;
    localparam int ACC_MINUS_LSB = 0;
    localparam int ACC_GIE_BIT = 7;
    localparam int ACC_PERIPHERAL_IRQ_EN_BIT = 6;
    localparam logic [7:0] ACC_CTRL_RESET = 8'h1f;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ACC_EDGE_NONE = 2'b00,
        ACC_EDGE_RISE = 2'b01,
        ACC_EDGE_FALL = 2'b10,
        ACC_EDGE_ANY = 2'b11
    } acc_edge_t;

    typedef enum logic [1:0] {
        ACC_MINUS_DEFAULT = 2'b00,
        ACC_MINUS_C = 2'b01,
        ACC_MINUS_B = 2'b10,
        ACC_MINUS_BANDGAP = 2'b11
    } acc_minus_t;

    typedef struct packed {
        logic on;
        logic pin_en;
        logic invert;
        acc_edge_t edge_sel;
        logic plus_sel;
        acc_minus_t minus_sel;
    } acc_ctrl_t;

    typedef struct packed {
        logic [1:0] minus_sel;
        logic plus_sel;
        logic on;
    } acc_analog_t;
endpackage

// *** src/acc_edge.sv ***
// Edge detector and event flag for one comparator.
`timescale 1ns/1ps
module acc_edge
    import acc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic reset_in,
    // Configuration.
    input wire acc_edge_t edge_sel_in,
    input wire logic mode_any_set_in,
    // Result and software access.
    input wire logic result_in,
    input wire logic sw_write_in,
    input wire logic sw_data_in,
    output logic flag_out
);
    logic prev_reg;
    logic flag_reg;
    logic flag_next;
    wire logic rise = result_in & ~prev_reg;
    wire logic fall = ~result_in & prev_reg;
    wire logic event_hit = (edge_sel_in == ACC_EDGE_RISE && rise)
        || (edge_sel_in == ACC_EDGE_FALL && fall)
        || (edge_sel_in == ACC_EDGE_ANY && (rise || fall));
    wire logic hw_set = event_hit | mode_any_set_in;

    // Hardware set wins over a software clear in the same cycle.
    always_comb
    begin
        flag_next = flag_reg;
        if (sw_write_in)
        begin
            flag_next = sw_data_in;
        end
        if (hw_set)
        begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            prev_reg <= 1'b0;
            flag_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= result_in;
            flag_reg <= flag_next;
        end
    end

    assign flag_out = flag_reg;
endmodule

// *** src/acc_sync.sv ***
// Two-flop synchroniser for asynchronous comparator results.
`timescale 1ns/1ps
module acc_sync
    import acc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic reset_in,
    // Data.
    input wire logic [ACC_NUM-1:0] async_in,
    output logic [ACC_NUM-1:0] sync_out
);
    logic [ACC_NUM-1:0] meta_reg;
    logic [ACC_NUM-1:0] sync_reg;

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// *** src/acc_top.sv ***
// Comparator control block: registers, input selection, output routing and events.
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic reset_in,
    // AXI4-Lite write address and data.
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read.
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Analog front end.
    input wire logic [ACC_NUM-1:0] raw_result_in,
    output acc_analog_t [ACC_NUM-1:0] analog_cfg_out,
    // Remappable pins.
    input wire logic [ACC_NUM-1:0] pin_direction_bits_in,
    output logic [ACC_NUM-1:0] pin_sel_out,
    output logic [ACC_NUM-1:0] compare_result_out,
    output logic [ACC_NUM-1:0] compare_result_oe_out,
    // Interrupt request and sleep wake.
    input wire logic sleep_in,
    output logic irq_out,
    output logic wake_out
);
    acc_ctrl_t [ACC_NUM-1:0] ctrl_reg;
    logic [ACC_NUM-1:0] irq_en_reg;
    logic [1:0] irqctl_reg;
    logic [ACC_NUM-1:0] any_set_reg;
    logic aw_full_reg;
    logic [7:0] aw_addr_reg;
    logic w_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [ACC_NUM-1:0] sync_result;
    logic [ACC_NUM-1:0] result;
    logic [ACC_NUM-1:0] flags;
    logic [ACC_NUM-1:0] pin_out_reg;

    // True when the address names a mapped register.
    function automatic logic acc_mapped(input logic [7:0] addr);
        return addr == ACC_CTRL0_OFS || addr == ACC_CTRL1_OFS || addr == ACC_CTRL2_OFS
            || addr == ACC_RESULT_OFS || addr == ACC_FLAG_OFS
            || addr == ACC_ENABLE_OFS || addr == ACC_IRQCTL_OFS;
    endfunction

    // Write path: address and data are held until both are present.
    wire logic wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    wire logic wr_byte0 = wr_go && w_strb_reg[0];
    wire logic [7:0] wr_byte = w_data_reg[7:0];
    wire logic wr_ctrl0 = wr_byte0 && aw_addr_reg == ACC_CTRL0_OFS;
    wire logic wr_ctrl1 = wr_byte0 && aw_addr_reg == ACC_CTRL1_OFS;
    wire logic wr_ctrl2 = wr_byte0 && aw_addr_reg == ACC_CTRL2_OFS;
    wire logic wr_flag = wr_byte0 && aw_addr_reg == ACC_FLAG_OFS;
    wire logic wr_enable = wr_byte0 && aw_addr_reg == ACC_ENABLE_OFS;
    wire logic wr_irqctl = wr_byte0 && aw_addr_reg == ACC_IRQCTL_OFS;
    wire logic [ACC_NUM-1:0] wr_ctrl = {wr_ctrl2, wr_ctrl1, wr_ctrl0};

    assign s_axi_awready_out = !aw_full_reg;
    assign s_axi_wready_out = !w_full_reg;
    assign s_axi_arready_out = !rvalid_reg;
    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out = bresp_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rdata_out = rdata_reg;
    assign s_axi_rresp_out = rresp_reg;

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= AXI_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_in && !aw_full_reg)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && !w_full_reg)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            if (wr_go)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= acc_mapped(aw_addr_reg) ? AXI_OKAY : AXI_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready_in)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Control registers; only reset and bus writes touch them, so sleep and wake leave them alone.
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            for (int i = 0; i < ACC_NUM; i++)
            begin
                ctrl_reg[i] <= acc_ctrl_t'(ACC_CTRL_RESET);
            end
            irq_en_reg <= '0;
            irqctl_reg <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < ACC_NUM; i++)
            begin
                if (wr_ctrl[i])
                begin
                    ctrl_reg[i] <= acc_ctrl_t'(wr_byte);
                end
            end
            if (wr_enable)
            begin
                irq_en_reg <= wr_byte[ACC_NUM-1:0];
            end
            if (wr_irqctl)
            begin
                irqctl_reg <= wr_byte[ACC_GIE_BIT:ACC_PERIPHERAL_IRQ_EN_BIT];
            end
        end
    end

    // Selecting any-change mode sets the flag once, the cycle after the write.
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            any_set_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < ACC_NUM; i++)
            begin
                any_set_reg[i] <= wr_ctrl[i]
                    && wr_byte[ACC_EDGE_LSB+1:ACC_EDGE_LSB] == ACC_EDGE_ANY;
            end
        end
    end

    acc_sync u_sync (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(raw_result_in),
        .sync_out(sync_result)
    );

    genvar g;
    generate
        for (g = 0; g < ACC_NUM; g++)
        begin : g_cmp
            // An off comparator reads low; polarity is applied before edges.
            assign result[g] = ctrl_reg[g].on
                & (sync_result[g] ^ ctrl_reg[g].invert);
            assign analog_cfg_out[g].on = ctrl_reg[g].on;
            assign analog_cfg_out[g].plus_sel = ctrl_reg[g].plus_sel;
            assign analog_cfg_out[g].minus_sel = ctrl_reg[g].minus_sel;
            assign pin_sel_out[g] = ctrl_reg[g].pin_en;
            assign compare_result_oe_out[g] = ctrl_reg[g].pin_en
                & ~pin_direction_bits_in[g];

            acc_edge u_edge (
                .mclk_in(mclk_in),
                .reset_in(reset_in),
                .edge_sel_in(ctrl_reg[g].edge_sel),
                .mode_any_set_in(any_set_reg[g]),
                .result_in(result[g]),
                .sw_write_in(wr_flag),
                .sw_data_in(wr_byte[g]),
                .flag_out(flags[g])
            );
        end
    endgenerate

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            pin_out_reg <= '0;
        end
        else
        begin
            pin_out_reg <= result;
        end
    end
    assign compare_result_out = pin_out_reg;

    // Interrupt needs all three enables; wake ignores the global enable.
    wire logic [ACC_NUM-1:0] live = flags & irq_en_reg;
    assign irq_out = (|live) & irqctl_reg[1] & irqctl_reg[0];
    assign wake_out = sleep_in & (|live);

    // Read path.
    wire logic [7:0] rd_addr = s_axi_araddr_in;
    wire logic [31:0] rd_word =
        rd_addr == ACC_CTRL0_OFS ? {24'h000000, ctrl_reg[0]} :
        rd_addr == ACC_CTRL1_OFS ? {24'h000000, ctrl_reg[1]} :
        rd_addr == ACC_CTRL2_OFS ? {24'h000000, ctrl_reg[2]} :
        rd_addr == ACC_RESULT_OFS ? {29'h0, result} :
        rd_addr == ACC_FLAG_OFS ? {29'h0, flags} :
        rd_addr == ACC_ENABLE_OFS ? {29'h0, irq_en_reg} :
        rd_addr == ACC_IRQCTL_OFS ? {24'h000000, irqctl_reg, 6'h00} :
        32'h0000_0000;

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= AXI_OKAY;
        end
        else if (s_axi_arvalid_in && !rvalid_reg)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= acc_mapped(rd_addr) ? AXI_OKAY : AXI_SLVERR;
        end
        else if (rvalid_reg && s_axi_rready_in)
        begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule

// *** testbench/acc_analog_model.sv ***
// Behavioural model of the analog sources and comparator cells.
`timescale 1ns/1ps
module acc_analog_model
    import acc_pkg::*;
(
    // Clock.
    input wire logic mclk_in,
    // Levels: plus pin, ladder, then the minus sources in select-code order.
    input wire logic [7:0] lvl_in [6],
    // Selections and raw results.
    input wire acc_analog_t [ACC_NUM-1:0] cfg_in,
    output logic [ACC_NUM-1:0] raw_out
);
    // A powered-down cell gives no usable level, so it chatters every cycle.
    logic chatter = 1'b0;
    always_ff @(posedge mclk_in)
    begin
        chatter <= ~chatter;
    end
    // Every selected source is taken to be set up as an analog input.
    always_comb
    begin
        for (int i = 0; i < ACC_NUM; i++)
        begin
            raw_out[i] = chatter;
            if (cfg_in[i].on)
            begin
                raw_out[i] = lvl_in[cfg_in[i].plus_sel] >
                    lvl_in[2 + cfg_in[i].minus_sel];
            end
        end
    end
endmodule

// *** testbench/acc_top_asserts.sv ***
// Concurrent checks on the comparator control block's ports.
`timescale 1ns/1ps
module acc_top_asserts
    import acc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic reset_in,
    // Bus handshakes.
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    // Comparator side.
    input wire acc_analog_t [ACC_NUM-1:0] analog_cfg_out,
    input wire logic [ACC_NUM-1:0] pin_direction_bits_in,
    input wire logic [ACC_NUM-1:0] pin_sel_out,
    input wire logic [ACC_NUM-1:0] compare_result_out,
    input wire logic [ACC_NUM-1:0] compare_result_oe_out,
    input wire logic sleep_in,
    input wire logic irq_out,
    input wire logic wake_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    logic [ACC_NUM-1:0] on_vec;
    assign on_vec = {analog_cfg_out[2].on, analog_cfg_out[1].on, analog_cfg_out[0].on};
    sequence s_write_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    // Both halves sit in holding registers for one cycle before the response rises.
    a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid_out)
        else $error("write response missing");
    a_read_answer: assert property (s_read_taken |=> s_axi_rvalid_out)
        else $error("read data missing");
    a_resp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("response dropped");
    a_pin_gate: assert property (
        compare_result_oe_out == (pin_sel_out & ~pin_direction_bits_in))
        else $error("pin driver enable wrong");
    a_off_quiet: assert property (
        (compare_result_out & ~$past(on_vec)) == 3'h0) else $error("result while off");
    a_reset_state: assert property (
        $fell(reset_in) |-> analog_cfg_out == 12'heee && !pin_sel_out)
        else $error("control not at reset value");
    a_irq_wakes: assert property (
        irq_out && sleep_in |-> wake_out) else $error("no wake on interrupt");
    a_sleep_keep: assert property (
        $fell(sleep_in) |-> $stable(analog_cfg_out)) else $error("control changed on wake");
endmodule
bind acc_top acc_top_asserts chk (.*);

// *** testbench/acc_top_bench.sv ***
// Self-checking bench for the comparator control block.
`timescale 1ns/1ps
`define CHK(n, x, y) begin checked++; if ((y) !== (x)) begin n_fail++; \
    $display("MISMATCH %s exp %0h got %0h", n, x, y); end end
module acc_top_bench
    import acc_pkg::*;
;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] s_axi_awaddr_in = 8'h00;
    logic [7:0] s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic s_axi_awvalid_in = 1'b0;
    logic s_axi_wvalid_in = 1'b0;
    logic s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0;
    logic s_axi_rready_in = 1'b0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [31:0] s_axi_rdata_out;
    acc_analog_t [ACC_NUM-1:0] analog_cfg_out;
    logic [ACC_NUM-1:0] raw_result_in, pin_sel_out, compare_result_out, compare_result_oe_out;
    logic [ACC_NUM-1:0] pin_direction_bits_in = 3'h7;
    logic sleep_in = 1'b0;
    logic irq_out, wake_out;
    logic [7:0] lvl [6] = '{8'h82, 8'h64, 8'hc8, 8'h96, 8'h32, 8'h78};
    logic e;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;

    acc_analog_model model (
        .mclk_in(mclk_in),
        .lvl_in(lvl),
        .cfg_in(analog_cfg_out),
        .raw_out(raw_result_in)
    );
    acc_top dut (.*);

    always #12.5 mclk_in = ~mclk_in;

    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a > ACC_IRQCTL_OFS) ? AXI_SLVERR : AXI_OKAY;
    endfunction
    function automatic logic ev(input int k, input logic up);
        return k % 4 == 3 || (k % 4 == 1 && up) || (k % 4 == 2 && !up);
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    // Ready is raised a cycle late so the response has to stand.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta;
        logic tw;
        @(posedge mclk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= {24'h0, d};
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        ta = 1'b0;
        tw = 1'b0;
        while (!(ta && tw))
        begin
            @(posedge mclk_in);
            ta = ta || s_axi_awready_out;
            tw = tw || s_axi_wready_out;
            s_axi_awvalid_in <= !ta;
            s_axi_wvalid_in <= !tw;
        end
        while (!s_axi_bvalid_out) @(posedge mclk_in);
        s_axi_bready_in <= 1'b1;
        @(posedge mclk_in);
        `CHK("bresp", resp_of(a), s_axi_bresp_out)
        s_axi_bready_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge mclk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        @(posedge mclk_in);
        while (!s_axi_arready_out) @(posedge mclk_in);
        s_axi_arvalid_in <= 1'b0;
        @(posedge mclk_in);
        while (!s_axi_rvalid_out) @(posedge mclk_in);
        s_axi_rready_in <= 1'b1;
        @(posedge mclk_in);
        `CHK("rdata", {24'h0, x}, s_axi_rdata_out)
        `CHK("rresp", resp_of(a), s_axi_rresp_out)
        s_axi_rready_in <= 1'b0;
    endtask
    task automatic end_sim;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge mclk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            end_sim();
        end
    end

    initial
    begin
        step(3);
        reset_in <= 1'b0;
        for (int i = 0; i < 3; i++)
            rd(ACC_CTRL0_OFS + 8'(4 * i), ACC_CTRL_RESET);
        rd(ACC_FLAG_OFS, 8'h00);
        rd(8'h1c, 8'h00);
        wr(8'h1c, 8'h55);
        // Every plus and minus source, with comparator 1 inverted.
        for (int c = 0; c < 8; c++)
        begin
            wr(ACC_CTRL0_OFS, 8'h80 | 8'(c));
            wr(ACC_CTRL1_OFS, 8'ha0 | 8'(c));
            wr(ACC_CTRL2_OFS, 8'h80 | 8'(c));
            step(3);
            e = lvl[c / 4] > lvl[2 + c % 4];
            rd(ACC_RESULT_OFS, {5'h0, e, !e, e});
        end
        // Every event mode, plain and inverted, on a rise and then a fall.
        for (int k = 0; k < 8; k++)
        begin
            lvl[0] <= 8'h0a;
            wr(ACC_CTRL0_OFS, 8'h82 | 8'(k << 3));
            step(4);
            if (k % 4 == 3)
                rd(ACC_FLAG_OFS, 8'h01);
            wr(ACC_FLAG_OFS, 8'h00);
            rd(ACC_FLAG_OFS, 8'h00);
            lvl[0] <= 8'h82;
            step(4);
            rd(ACC_FLAG_OFS, {7'h0, ev(k, !k[2])});
            wr(ACC_FLAG_OFS, 8'h00);
            lvl[0] <= 8'h0a;
            step(4);
            rd(ACC_FLAG_OFS, {7'h0, ev(k, k[2])});
        end
        lvl[0] <= 8'h82;
        wr(ACC_CTRL0_OFS, 8'hc2);
        pin_direction_bits_in <= 3'h6;
        step(4);
        `CHK("pin_sel", 3'h1, pin_sel_out)
        `CHK("pin_oe", 3'h1, compare_result_oe_out)
        `CHK("pin_out", 3'h3, compare_result_out)
        pin_direction_bits_in <= 3'h7;
        step(1);
        `CHK("pin_gate", 3'h0, compare_result_oe_out)
        wr(ACC_FLAG_OFS, 8'h01);
        rd(ACC_FLAG_OFS, 8'h01);
        sleep_in <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            wr(ACC_ENABLE_OFS, {7'h0, k[0]});
            wr(ACC_IRQCTL_OFS, {k[2], k[1], 6'h0});
            `CHK("irq", k == 7, irq_out)
            `CHK("wake", k[0], wake_out)
        end
        sleep_in <= 1'b0;
        step(2);
        rd(ACC_CTRL0_OFS, 8'hc2);
        // A write without the low byte lane must leave the register alone.
        s_axi_wstrb_in <= 4'he;
        wr(ACC_CTRL0_OFS, 8'h00);
        s_axi_wstrb_in <= 4'hf;
        rd(ACC_CTRL0_OFS, 8'hc2);
        reset_in <= 1'b1;
        step(3);
        reset_in <= 1'b0;
        rd(ACC_CTRL0_OFS, ACC_CTRL_RESET);
        rd(ACC_FLAG_OFS, 8'h00);
        `CHK("irq_rst", 1'b0, irq_out)
        `CHK("out_rst", 3'h0, compare_result_out)
        end_sim();
    end
endmodule
